// file: cbsc_pkg.sv
// Purpose: shared constants and types for the clock buffer SMBus control
// Assumes: both ends run on a 125 MHz mclk
// Notes: the SMBus host derives the bus clock by a divider
// Behaviour
// - Device is slave only, indexed block access.
// - Answers address 1101110; direction bit follows.
// - Offset byte sets start index, auto-increments.
// - Host never writes with count zero.
// - Mode bit 0: divide by two or normal.
// - Mode bit 1: fanout or PLL operation.
// - Mode bit 2: high or low bandwidth.
// - Mode bit 6: stop input drives or floats.
// - Mode bit 7: power-down drives or floats.
// - Enable byte bits 1,2,5,6 gate pairs.
// - Enable pins gate pairs 0 and 3.
// - Polarity pin inverts enables, stop, power-down.
// - Stop input active low stops outputs.
// - Power-down input active low.
// - Stop or power-down low stops all outputs.
// - Host releases bus lines during power-down; the host watches power_down_n low only and ignores the polarity pin.
// - Select pin chooses fanout or PLL; the code runs PLL only if mode bit 1 is also set.
// - Select pin chooses loop bandwidth; the code gives low bandwidth only if mode bit 2 is also set.
package cbsc_pkg;
	localparam logic [6:0] DEV_ADDR  = 7'h6e;
	localparam logic [7:0] OFS_MODE  = 8'h00;
	localparam logic [7:0] OFS_EN    = 8'h01;
	localparam logic [7:0] MODE_RST  = 8'h07;
	localparam logic [7:0] MODE_MASK = 8'hc7;
	localparam logic [7:0] EN_RST    = 8'h66;
	localparam logic [7:0] EN_MASK   = 8'h66;
	localparam int         MODE_FULL = 0;
	localparam int         MODE_PLL  = 1;
	localparam int         MODE_LBW  = 2;
	localparam int         MODE_STOP = 6;
	localparam int         MODE_PD   = 7;
	localparam int         EN_POS [4] = '{1, 2, 5, 6};
	localparam logic [3:0] LAST_BIT  = 4'h8;
	localparam int         CLK_NS    = 8;
	localparam int         SCL_HALF_NS  = 1250;
	localparam int         SCL_HALF_CYC = SCL_HALF_NS / CLK_NS;
	localparam logic [3:0] HA_OFFSET = 4'h0;
	localparam logic [3:0] HA_COUNT  = 4'h1;
	localparam logic [3:0] HA_CTRL   = 4'h2;
	localparam logic [3:0] HA_STAT   = 4'h3;
	localparam logic [1:0] HA_DATA   = 2'h1;
	localparam int         CTRL_GO   = 0;
	localparam int         CTRL_READ = 1;
	localparam int         STAT_BUSY = 0;
	localparam int         STAT_NACK = 1;
	localparam int         STAT_PD   = 2;
	localparam logic [8:0] HDR_FRAMES = 9'h003;

	typedef enum logic [2:0] {
		DS_IDLE  = 3'b000,
		DS_ADDR  = 3'b001,
		DS_OFFS  = 3'b010,
		DS_CNT   = 3'b011,
		DS_WDATA = 3'b100,
		DS_RDATA = 3'b101,
		DS_SKIP  = 3'b110
	} cbsc_dstate_t;

	typedef enum logic [2:0] {
		HS_IDLE  = 3'b000,
		HS_START = 3'b001,
		HS_LOW   = 3'b010,
		HS_HIGH  = 3'b011,
		HS_STOP1 = 3'b100,
		HS_STOP2 = 3'b101
	} cbsc_hstate_t;
endpackage : cbsc_pkg

// file: cbsc_smbus_if.sv
// Purpose: SMBus wires between the clock buffer and its host
// Assumes: open-drain lines with pull-ups; enables are active low
// Notes: a released line reads high
`timescale 1ns/1ps
interface cbsc_smbus_if;
	logic scl_o;
	logic scl_oe_n;
	logic hst_sda_o;
	logic hst_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;

	assign scl = scl_oe_n | scl_o;
	assign sda = (hst_sda_oe_n | hst_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport device (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);
	modport host (
		input  sda,
		output scl_o,
		output scl_oe_n,
		output hst_sda_o,
		output hst_sda_oe_n
	);
endinterface : cbsc_smbus_if

// file: cbsc_device.sv
// Purpose: SMBus slave and output gating of the four-pair clock buffer
// Assumes: bus lines and pins are asynchronous to mclk
// Notes: outputs are control levels for the analog output stage
`timescale 1ns/1ps
module cbsc_device (
	// Clock, reset, freeze
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       ce,
	// SMBus link
	cbsc_smbus_if.device    bus,
	// Control pins
	input  wire logic       oe0_pin,
	input  wire logic       oe3_pin,
	input  wire logic       control_polarity_select,
	input  wire logic       clock_stop_n,
	input  wire logic       power_down_n,
	input  wire logic       pll_mode_select,
	input  wire logic       loop_bandwidth_select,
	// Output path control
	output wire logic [3:0] out_run,
	output wire logic [3:0] out_float,
	output logic            out_full_rate,
	output logic            pll_on,
	output logic            low_bandwidth
);
	import cbsc_pkg::*;

	logic [8:0]   pin_raw;
	logic [8:0]   sync1_reg;
	logic [8:0]   sync2_reg;
	logic         scl_s;
	logic         sda_s;
	logic         scl_d_reg;
	logic         sda_d_reg;
	logic         start_ev;
	logic         stop_ev;
	logic         scl_rise;
	logic         scl_fall;
	cbsc_dstate_t state_reg;
	logic         ack_reg;
	logic [3:0]   bit_reg;
	logic [7:0]   shift_reg;
	logic [7:0]   index_reg;
	logic [7:0]   count_reg;
	logic         rw_reg;
	logic         nack_reg;
	logic         oe_n_reg;
	logic [7:0]   mode_reg;
	logic [7:0]   en_reg;
	logic [7:0]   rd_byte;
	logic         wr_fire;
	logic         inv;
	logic         stop_act;
	logic         pd_act;
	logic [3:0]   pin_en;

	assign pin_raw = {bus.scl, bus.sda, power_down_n, clock_stop_n,
		control_polarity_select, oe3_pin, oe0_pin, pll_mode_select,
		loop_bandwidth_select};

	// Two-stage synchronisers for every asynchronous input
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sync1_reg <= 9'h1ff;
			sync2_reg <= 9'h1ff;
		end
		else if (ce)
		begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	assign scl_s = sync2_reg[8];
	assign sda_s = sync2_reg[7];

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
		end
		else if (ce)
		begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
		end
	end

	// Start and stop only while the clock stays high
	assign start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;

	// Unmapped offsets read as zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (index_reg == OFS_MODE)
			rd_byte = mode_reg;
		else if (index_reg == OFS_EN)
			rd_byte = en_reg;
	end

	assign wr_fire = ce & ~start_ev & ~stop_ev & scl_fall & ~ack_reg
		& (state_reg == DS_WDATA) & (bit_reg == LAST_BIT);

	// Protocol engine; data moves only while the clock is low
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg <= DS_IDLE;
			ack_reg   <= 1'b0;
			bit_reg   <= 4'h0;
			shift_reg <= 8'h00;
			index_reg <= 8'h00;
			count_reg <= 8'h00;
			rw_reg    <= 1'b0;
			nack_reg  <= 1'b0;
			oe_n_reg  <= 1'b1;
		end
		else if (ce)
		begin
			if (start_ev)
			begin
				state_reg <= DS_ADDR;
				ack_reg   <= 1'b0;
				bit_reg   <= 4'h0;
				oe_n_reg  <= 1'b1;
			end
			else if (stop_ev)
			begin
				state_reg <= DS_IDLE;
				ack_reg   <= 1'b0;
				oe_n_reg  <= 1'b1;
			end
			else
			begin
				unique case (state_reg)
				DS_IDLE, DS_SKIP:
					oe_n_reg <= 1'b1;
				DS_ADDR, DS_OFFS, DS_CNT, DS_WDATA:
				begin
					if (!ack_reg)
					begin
						if (scl_rise)
						begin
							shift_reg <= {shift_reg[6:0], sda_s};
							bit_reg   <= bit_reg + 4'h1;
						end
						else if (scl_fall && bit_reg == LAST_BIT)
						begin
							bit_reg <= 4'h0;
							// Foreign address: stay silent until the next start or stop
							if (state_reg == DS_ADDR
								&& shift_reg[7:1] != DEV_ADDR)
								state_reg <= DS_SKIP;
							else
							begin
								ack_reg  <= 1'b1;
								oe_n_reg <= 1'b0;
							end
							if (state_reg == DS_ADDR)
								rw_reg <= shift_reg[0];
							if (state_reg == DS_OFFS)
								index_reg <= shift_reg;
							if (state_reg == DS_CNT)
								count_reg <= shift_reg;
							if (state_reg == DS_WDATA)
							begin
								index_reg <= index_reg + 8'h01;
								count_reg <= count_reg - 8'h01;
							end
						end
					end
					else if (scl_fall)
					begin
						ack_reg  <= 1'b0;
						oe_n_reg <= 1'b1;
						if (state_reg == DS_ADDR)
							state_reg <= DS_OFFS;
						else if (state_reg == DS_OFFS)
							state_reg <= DS_CNT;
						else if (count_reg == 8'h00)
							state_reg <= DS_SKIP;
						else if (state_reg == DS_CNT && rw_reg)
						begin
							state_reg <= DS_RDATA;
							shift_reg <= rd_byte;
							oe_n_reg  <= rd_byte[7];
						end
						else
							state_reg <= DS_WDATA;
					end
				end
				DS_RDATA:
				begin
					if (!ack_reg)
					begin
						if (scl_rise)
							bit_reg <= bit_reg + 4'h1;
						else if (scl_fall && bit_reg == LAST_BIT)
						begin
							bit_reg   <= 4'h0;
							ack_reg   <= 1'b1;
							oe_n_reg  <= 1'b1;
							index_reg <= index_reg + 8'h01;
							count_reg <= count_reg - 8'h01;
						end
						else if (scl_fall)
						begin
							shift_reg <= {shift_reg[6:0], 1'b1};
							oe_n_reg  <= shift_reg[6];
						end
					end
					else if (scl_rise)
						nack_reg <= sda_s;
					else if (scl_fall)
					begin
						ack_reg <= 1'b0;
						// Host refusal or count spent ends the burst
						if (nack_reg || count_reg == 8'h00)
							state_reg <= DS_SKIP;
						else
						begin
							shift_reg <= rd_byte;
							oe_n_reg  <= rd_byte[7];
						end
					end
				end
				default:
					state_reg <= DS_IDLE;
				endcase
			end
		end
	end

	// Control bytes; reserved bits stay zero
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_reg <= MODE_RST;
			en_reg   <= EN_RST;
		end
		else if (wr_fire)
		begin
			if (index_reg == OFS_MODE)
				mode_reg <= shift_reg & MODE_MASK;
			else if (index_reg == OFS_EN)
				en_reg <= shift_reg & EN_MASK;
		end
	end

	// Open drain: only ever pulls low
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = oe_n_reg;

	assign inv      = sync2_reg[4];
	assign pd_act   = ~(sync2_reg[6] ^ inv);
	assign stop_act = ~(sync2_reg[5] ^ inv);
	assign pin_en   = {sync2_reg[3] ^ inv, 2'b11, sync2_reg[2] ^ inv};

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_pair
			logic run_reg;
			logic float_reg;
			always_ff @(posedge mclk or negedge nrst)
			begin
				if (!nrst)
				begin
					run_reg   <= 1'b0;
					float_reg <= 1'b0;
				end
				else if (ce)
				begin
					run_reg <= en_reg[EN_POS[g]] & pin_en[g]
						& ~stop_act & ~pd_act;
					// Power-down takes precedence over stop
					if (pd_act)
						float_reg <= mode_reg[MODE_PD];
					else if (stop_act)
						float_reg <= mode_reg[MODE_STOP];
					else
						float_reg <= 1'b0;
				end
			end
			assign out_run[g]   = run_reg;
			assign out_float[g] = float_reg;
		end
	endgenerate

	// Pin and register must both ask for PLL or low bandwidth
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			out_full_rate <= 1'b1;
			pll_on        <= 1'b0;
			low_bandwidth <= 1'b0;
		end
		else if (ce)
		begin
			out_full_rate <= mode_reg[MODE_FULL];
			pll_on        <= mode_reg[MODE_PLL] & sync2_reg[1];
			low_bandwidth <= mode_reg[MODE_LBW] & sync2_reg[0];
		end
	end
endmodule : cbsc_device

// file: cbsc_host.sv
// Purpose: SMBus host issuing indexed block reads and writes
// Assumes: software uses the plain register port
// Notes: four data bytes; longer counts reuse them modulo four
`timescale 1ns/1ps
module cbsc_host (
	// Clock, reset, freeze
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic       ce,
	// SMBus link
	cbsc_smbus_if.host      bus,
	// Power-down pin of the device, asynchronous
	input  wire logic       power_down_n,
	// Register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic [7:0]      rdata
);
	import cbsc_pkg::*;

	logic [1:0]   sda_sync_reg;
	logic [1:0]   pd_sync_reg;
	logic         pd_act;
	cbsc_hstate_t state_reg;
	logic [7:0]   div_reg;
	logic         tick;
	logic [8:0]   frame_reg;
	logic [8:0]   tx_reg;
	logic [7:0]   rx_reg;
	logic [3:0]   bit_reg;
	logic [7:0]   off_reg;
	logic [7:0]   cnt_reg;
	logic         rw_reg;
	logic         nack_reg;
	logic         scl_oen_reg;
	logic         sda_oen_reg;
	logic [7:0]   mem [4];
	logic [8:0]   next_tx;
	logic [8:0]   next_frame;
	logic         go;
	logic         rd_cap;
	logic         last;

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			sda_sync_reg <= 2'b11;
			pd_sync_reg  <= 2'b11;
		end
		else if (ce)
		begin
			sda_sync_reg <= {sda_sync_reg[0], bus.sda};
			pd_sync_reg  <= {pd_sync_reg[0], power_down_n};
		end
	end
	assign pd_act = ~pd_sync_reg[1];

	assign tick = (div_reg == 8'(SCL_HALF_CYC - 1));
	assign next_frame = frame_reg + 9'h001;
	assign last = (next_frame == HDR_FRAMES + {1'b0, cnt_reg});
	assign rd_cap = rw_reg & (frame_reg >= HDR_FRAMES);
	// Zero-count writes are refused outright
	assign go = wr & (addr == HA_CTRL) & wdata[CTRL_GO]
		& (state_reg == HS_IDLE) & ~pd_act
		& (wdata[CTRL_READ] | cnt_reg != 8'h00);

	// Bits of the next frame, ack slot last
	always_comb
	begin
		next_tx = {8'hff, 1'b1};
		if (next_frame == 9'h001)
			next_tx = {off_reg, 1'b1};
		else if (next_frame == 9'h002)
			next_tx = {cnt_reg, 1'b1};
		else if (rw_reg)
			next_tx = {8'hff, 1'b0};
		else
			next_tx = {mem[2'(next_frame - HDR_FRAMES)], 1'b1};
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			div_reg <= 8'h00;
		else if (ce)
		begin
			if (state_reg == HS_IDLE || tick)
				div_reg <= 8'h00;
			else
				div_reg <= div_reg + 8'h01;
		end
	end

	// Bit engine; the host makes the bus clock itself
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_reg   <= HS_IDLE;
			frame_reg   <= 9'h000;
			tx_reg      <= 9'h1ff;
			rx_reg      <= 8'h00;
			bit_reg     <= 4'h0;
			nack_reg    <= 1'b0;
			rw_reg      <= 1'b0;
			scl_oen_reg <= 1'b1;
			sda_oen_reg <= 1'b1;
		end
		else if (ce)
		begin
			if (pd_act)
			begin
				state_reg   <= HS_IDLE;
				scl_oen_reg <= 1'b1;
				sda_oen_reg <= 1'b1;
			end
			else if (go)
			begin
				state_reg   <= HS_START;
				sda_oen_reg <= 1'b0;
				rw_reg      <= wdata[CTRL_READ];
				nack_reg    <= 1'b0;
				frame_reg   <= 9'h000;
				bit_reg     <= 4'h0;
			end
			else if (tick)
			begin
				unique case (state_reg)
				HS_IDLE:
					scl_oen_reg <= 1'b1;
				HS_START:
				begin
					state_reg   <= HS_LOW;
					scl_oen_reg <= 1'b0;
					tx_reg      <= {DEV_ADDR, rw_reg, 1'b1};
					sda_oen_reg <= DEV_ADDR[6];
				end
				HS_LOW:
				begin
					state_reg   <= HS_HIGH;
					scl_oen_reg <= 1'b1;
				end
				HS_HIGH:
				begin
					scl_oen_reg <= 1'b0;
					bit_reg     <= bit_reg + 4'h1;
					state_reg   <= HS_LOW;
					if (bit_reg != LAST_BIT)
					begin
						rx_reg      <= {rx_reg[6:0], sda_sync_reg[1]};
						tx_reg      <= {tx_reg[7:0], 1'b1};
						sda_oen_reg <= tx_reg[7];
					end
					else
					begin
						bit_reg   <= 4'h0;
						frame_reg <= next_frame;
						if (!rd_cap && sda_sync_reg[1])
						begin
							nack_reg    <= 1'b1;
							state_reg   <= HS_STOP1;
							sda_oen_reg <= 1'b0;
						end
						else if (last)
						begin
							state_reg   <= HS_STOP1;
							sda_oen_reg <= 1'b0;
						end
						else
						begin
							// Top bit is the one on the wire now
							tx_reg      <= next_tx;
							sda_oen_reg <= next_tx[8];
						end
					end
				end
				HS_STOP1:
				begin
					state_reg   <= HS_STOP2;
					scl_oen_reg <= 1'b1;
				end
				HS_STOP2:
				begin
					state_reg   <= HS_IDLE;
					sda_oen_reg <= 1'b1;
				end
				default:
					state_reg <= HS_IDLE;
				endcase
			end
		end
	end

	// Data bytes: software writes, read bursts fill
	always_ff @(posedge mclk)
	begin
		if (ce && tick && state_reg == HS_HIGH
			&& bit_reg == LAST_BIT && rd_cap)
			mem[2'(frame_reg - HDR_FRAMES)] <= rx_reg;
		else if (ce && wr && addr[3:2] == HA_DATA && state_reg == HS_IDLE)
			mem[addr[1:0]] <= wdata;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			off_reg <= 8'h00;
			cnt_reg <= 8'h01;
			rdata   <= 8'h00;
		end
		else if (ce)
		begin
			if (wr && state_reg == HS_IDLE && addr == HA_OFFSET)
				off_reg <= wdata;
			if (wr && state_reg == HS_IDLE && addr == HA_COUNT)
				cnt_reg <= wdata;
			if (rd)
			begin
				rdata <= 8'h00;
				if (addr == HA_OFFSET)
					rdata <= off_reg;
				else if (addr == HA_COUNT)
					rdata <= cnt_reg;
				else if (addr == HA_STAT)
					rdata <= {5'h00, pd_act, nack_reg,
						state_reg != HS_IDLE};
				else if (addr[3:2] == HA_DATA)
					rdata <= mem[addr[1:0]];
			end
		end
	end

	assign bus.scl_o        = 1'b0;
	assign bus.scl_oe_n     = scl_oen_reg;
	assign bus.hst_sda_o    = 1'b0;
	assign bus.hst_sda_oe_n = sda_oen_reg;
endmodule : cbsc_host

// file: cbsc_checker.sv
// Purpose: wire-level checks of the clock buffer SMBus link
// Assumes: one mclk domain; host lines come straight from flops
// Notes: a small frame decoder feeds the assertions
`timescale 1ns/1ps
module cbsc_checker
	import cbsc_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Bus wires and drivers
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe_n,
	input wire logic hst_sda_oe_n,
	input wire logic dev_sda_oe_n,
	// Device power-down pin
	input wire logic power_down_n
);
	logic       scl_d, sda_d, in_frame, addr_ok, is_read;
	logic [3:0] bit_cnt;
	logic [7:0] byte_cnt, sr, cnt_n, low_cnt;
	wire        up = scl & ~scl_d;
	wire        ack_slot = up & in_frame & (bit_cnt == LAST_BIT);

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
			in_frame <= 1'b0;
			addr_ok  <= 1'b0;
			is_read  <= 1'b0;
			bit_cnt  <= 4'h0;
			byte_cnt <= 8'h00;
			sr       <= 8'h00;
			cnt_n    <= 8'h00;
			low_cnt  <= 8'h00;
		end
		else
		begin
			scl_d   <= scl;
			sda_d   <= sda;
			low_cnt <= scl ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
			if (scl && scl_d && sda_d && !sda)
			begin
				in_frame <= 1'b1;
				bit_cnt  <= 4'h0;
				byte_cnt <= 8'h00;
			end
			else if (scl && scl_d && !sda_d && sda)
				in_frame <= 1'b0;
			else if (up && in_frame)
			begin
				bit_cnt <= (bit_cnt == LAST_BIT) ? 4'h0 : bit_cnt + 4'h1;
				if (bit_cnt == LAST_BIT)
					byte_cnt <= byte_cnt + 8'h01;
				else
					sr <= {sr[6:0], sda};
				if (bit_cnt == LAST_BIT && byte_cnt == 8'h00)
					addr_ok <= (sr[7:1] == DEV_ADDR);
				if (bit_cnt == LAST_BIT && byte_cnt == 8'h00)
					is_read <= sr[0];
				if (bit_cnt == LAST_BIT && byte_cnt == 8'h02)
					cnt_n <= sr;
			end
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_IDLE_QUIET: assert property (
		!in_frame |-> dev_sda_oe_n) else $error("device drove sda while idle");
	AST_HIGH_STABLE: assert property (
		scl && $past(scl) |-> $stable(dev_sda_oe_n))
		else $error("device changed sda while scl high");
	AST_ADDR_ACK: assert property (
		ack_slot && byte_cnt == 8'h00 && sr[7:1] == DEV_ADDR |-> !dev_sda_oe_n)
		else $error("own address not acknowledged");
	AST_OFFS_ACK: assert property (
		ack_slot && addr_ok && byte_cnt == 8'h01 |-> !dev_sda_oe_n)
		else $error("offset byte not acknowledged");
	AST_CNT_ACK: assert property (
		ack_slot && addr_ok && byte_cnt == 8'h02 |-> !dev_sda_oe_n)
		else $error("count byte not acknowledged");
	AST_HDR_QUIET: assert property (
		up && in_frame && byte_cnt < 8'h03 && bit_cnt != LAST_BIT
		|-> dev_sda_oe_n) else $error("device drove a header bit");
	AST_WDATA_ACK: assert property (
		ack_slot && addr_ok && !is_read && byte_cnt >= 8'h03
		&& byte_cnt < cnt_n + 8'h03 |-> !dev_sda_oe_n)
		else $error("write data byte not acknowledged");
	AST_RD_RELEASE: assert property (
		ack_slot && is_read && byte_cnt >= 8'h03 |-> dev_sda_oe_n)
		else $error("device held sda in host ack slot");
	AST_SCL_HALF: assert property (
		up && in_frame && bit_cnt != 4'h0
		|-> low_cnt inside {[SCL_HALF_CYC - 2 : SCL_HALF_CYC + 2]})
		else $error("scl low half period off");
	AST_PD_RELEASE: assert property (
		!power_down_n [*6] |-> scl_oe_n && hst_sda_oe_n)
		else $error("host drove the bus in power-down");

	COV_WRITE: cover property (ack_slot && !is_read && byte_cnt >= 8'h03);
	COV_READ: cover property (ack_slot && is_read && byte_cnt >= 8'h03);
	COV_PD: cover property (!power_down_n && scl_oe_n && !in_frame);
endmodule : cbsc_checker

// file: cbsc_test.sv
// Purpose: bench for both ends of the clock buffer SMBus control
// Assumes: the host register port starts all link traffic
// Notes: one byte on the link takes about 2800 mclk
`timescale 1ns/1ps
module cbsc_test;
	import cbsc_pkg::*;
	logic       mclk, nrst, wr, rd, pol, oe0, oe3, stop_n, pd_n;
	logic       pll_sel, bw_sel, full_rate, pll_on, low_bw;
	logic [3:0] addr, out_run, out_float;
	logic [7:0] wdata, rdata, v;
	int         err_count, check_count;
	logic [6:0] pin_tab [9] = '{7'h3f, 7'h3d, 7'h3e, 7'h1f, 7'h2f,
		7'h37, 7'h3b, 7'h43, 7'h7f};
	logic [9:0] exp_tab [9] = '{10'h3c3, 10'h3c1, 10'h3c2, 10'h383,
		10'h1c3, 10'h003, 10'h003, 10'h3c3, 10'h003};

	cbsc_smbus_if cbsc_smbus_if_i ();
	cbsc_device cbsc_device_i (.mclk(mclk), .nrst(nrst), .ce(1'b1),
		.bus(cbsc_smbus_if_i.device), .oe0_pin(oe0), .oe3_pin(oe3),
		.control_polarity_select(pol), .clock_stop_n(stop_n),
		.power_down_n(pd_n), .pll_mode_select(pll_sel),
		.loop_bandwidth_select(bw_sel), .out_run(out_run),
		.out_float(out_float), .out_full_rate(full_rate),
		.pll_on(pll_on), .low_bandwidth(low_bw));
	cbsc_host cbsc_host_i (.mclk(mclk), .nrst(nrst), .ce(1'b1),
		.bus(cbsc_smbus_if_i.host), .power_down_n(pd_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	cbsc_checker cbsc_checker_i (.mclk(mclk), .nrst(nrst),
		.scl(cbsc_smbus_if_i.scl), .sda(cbsc_smbus_if_i.sda),
		.scl_oe_n(cbsc_smbus_if_i.scl_oe_n),
		.hst_sda_oe_n(cbsc_smbus_if_i.hst_sda_oe_n),
		.dev_sda_oe_n(cbsc_smbus_if_i.dev_sda_oe_n), .power_down_n(pd_n));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		v = rdata;
	endtask : reg_rd

	// Pins pass two sync flops and an output flop
	task automatic pins(input logic [6:0] p);
		@(posedge mclk);
		{pol, oe0, oe3, stop_n, pd_n, pll_sel, bw_sel} <= p;
		repeat (6) @(posedge mclk);
	endtask : pins

	// One link frame; busy is polled with a bounded count
	task automatic frame(input logic [7:0] ofs, cnt, ctl, d0, d1);
		int n;
		reg_wr(HA_OFFSET, ofs);
		reg_wr(HA_COUNT, cnt);
		reg_wr({HA_DATA, 2'h0}, d0);
		reg_wr({HA_DATA, 2'h1}, d1);
		reg_wr(HA_CTRL, ctl);
		n = 0;
		v = 8'h01;
		while (v[STAT_BUSY] !== 1'b0 && n < 400)
		begin
			repeat (50) @(posedge mclk);
			reg_rd(HA_STAT);
			n++;
		end
		check({8'h00, v & 8'h03}, 16'h0000);
	endtask : frame

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Whole run needs about 41000 mclk; allow 60000
	initial
	begin
		#480_000;
		err_count++;
		results();
	end

	initial
	begin
		err_count   = 0;
		check_count = 0;
		nrst        = 1'b0;
		{wr, rd, addr, wdata} = '0;
		{pol, oe0, oe3, stop_n, pd_n, pll_sel, bw_sel} = 7'h3f;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		repeat (6) @(posedge mclk);
		check({15'h0, full_rate}, 16'h0001);
		for (int k = 0; k < 9; k++)
		begin
			pins(pin_tab[k]);
			check({6'h0, out_run, out_float, pll_on, low_bw},
				{6'h0, exp_tab[k]});
		end
		$display("test pins done");
		pins(7'h3f);
		reg_rd(4'h8);
		check({8'h00, v}, 16'h0000);
		// Reserved bits set on purpose; they must not stick
		frame(8'h00, 8'h02, 8'h01, 8'hb8, 8'ha3);
		pins(7'h3f);
		check({5'h0, out_run, out_float, full_rate, pll_on, low_bw},
			16'h0280);
		pins(7'h37);
		check({5'h0, out_run, out_float, full_rate, pll_on, low_bw},
			16'h0000);
		pins(7'h3b);
		check({5'h0, out_run, out_float, full_rate, pll_on, low_bw},
			16'h0078);
		reg_rd(HA_STAT);
		check({8'h00, v}, 16'h0004);
		$display("test write done");
		pins(7'h3f);
		frame(8'h00, 8'h02, 8'h03, 8'h00, 8'h00);
		reg_rd({HA_DATA, 2'h0});
		check({8'h00, v}, 16'h0080);
		reg_rd({HA_DATA, 2'h1});
		check({8'h00, v}, 16'h0022);
		$display("test read done");
		frame(8'h01, 8'h01, 8'h01, 8'h44, 8'h00);
		check({5'h0, out_run, out_float, full_rate, pll_on, low_bw},
			16'h0500);
		$display("test offset done");
		// Write with count zero must not start a frame
		reg_wr(HA_COUNT, 8'h00);
		reg_wr(HA_CTRL, 8'h01);
		reg_rd(HA_STAT);
		check({8'h00, v}, 16'h0000);
		$display("test refuse done");
		results();
	end
endmodule : cbsc_test
